// ---- rtl/ptm_pkg.sv ----
// Package for the 10-bit periodic timer: register map, field positions, modes.
// Assumes a byte-wide register port; offsets here are local indices.
package ptm_pkg;
  localparam int unsigned PTM_CNT_W = 10;
  localparam int unsigned PTM_ADDR_W = 3;
  // Register offsets
  localparam logic [2:0] PTM_OFS_CTRL0 = 3'h0;
  localparam logic [2:0] PTM_OFS_CTRL1 = 3'h1;
  localparam logic [2:0] PTM_OFS_CNT_LOW = 3'h2;
  localparam logic [2:0] PTM_OFS_CNT_HIGH = 3'h3;
  localparam logic [2:0] PTM_OFS_CMPA_LOW = 3'h4;
  localparam logic [2:0] PTM_OFS_CMPA_HIGH = 3'h5;
  localparam logic [2:0] PTM_OFS_PER_LOW = 3'h6;
  localparam logic [2:0] PTM_OFS_PER_HIGH = 3'h7;
  // Control zero: counter_on bit
  localparam int unsigned PTM_BIT_ON = 3;
  // Control one: fields
  localparam int unsigned PTM_BIT_MODE_HI = 7;
  localparam int unsigned PTM_BIT_MODE_LO = 6;
  localparam int unsigned PTM_BIT_ACT_HI = 5;
  localparam int unsigned PTM_BIT_ACT_LO = 4;
  localparam int unsigned PTM_BIT_INIT = 3;
  localparam int unsigned PTM_BIT_INV = 2;
  localparam int unsigned PTM_BIT_CLRSRC = 0;
  // Flag register (bit position in control zero, write one to clear)
  localparam int unsigned PTM_BIT_FLAG_A = 1;
  localparam int unsigned PTM_BIT_FLAG_P = 0;
  localparam logic [7:0] PTM_RST_BYTE = 8'h00;
  localparam logic [9:0] PTM_CNT_ZERO = 10'h000;
  localparam logic [9:0] PTM_CNT_MAX = 10'h3ff;
  localparam logic [9:0] PTM_CNT_ONE = 10'h001;

  typedef enum logic [1:0] {
    PTM_MODE_CMP = 2'b00,
    PTM_MODE_CAP = 2'b01,
    PTM_MODE_PWM = 2'b10,
    PTM_MODE_TMR = 2'b11
  } ptm_mode_e;

  // Pin action codes
  localparam logic [1:0] PTM_ACT_NONE = 2'b00;
  localparam logic [1:0] PTM_ACT_LOW = 2'b01;
  localparam logic [1:0] PTM_ACT_HIGH = 2'b10;
  localparam logic [1:0] PTM_ACT_TOGGLE = 2'b11;
  localparam logic [1:0] PTM_PWM_INACT = 2'b00;
  localparam logic [1:0] PTM_PWM_ACT = 2'b01;
  localparam logic [1:0] PTM_PWM_WAVE = 2'b10;
endpackage

// ---- rtl/ptm_timer.sv ----
// 10-bit periodic timer with compare A, period P and PWM output.
// Assumes a synchronous byte register port on mclk and a tick enable
// from an external clock-select divider on the same clock.
//
// Operation
// - Counter bits 9..8 read in counter high bits 1..0, rest zero.
// - Ten-bit compare A held in low and high byte, reset zero.
// - Ten-bit period P held in low and high byte, unused bits zero.
// - Two-bit mode select chooses among the operating modes.
// - Mode 00 selects compare-match output mode.
// - Clear source low: clear on P match, or overflow when P zero; both flags.
// - Clear source high: clear on A match, only A flag raised.
// - Compare A zero: no A flag; with clear source high the counter overflows at 3FF.
// - Compare mode: pin changes only on A match, never on P match.
// - On A match, pin goes high, low or toggles; action zero holds.
// - Counter-on rising sets pin to the initial level.
// - Mode 11 counts like compare mode; pin unused.
// - PWM ignores clear source; P sets frequency, A sets duty.
// - PWM raises A flag on A match and P flag on P match.
// - PWM: initial level is active level, action enables, invert flips.
// - Compare action: 01 low, 10 high, 11 toggle.
// - PWM period P, zero means 1024; duty at or above period full on.
// - Counter-on rising clears counter; falling holds count.
// - PWM action: 00 inactive, 01 active, 10 waveform.
`timescale 1ns/10ps
`default_nettype none

module ptm_timer
  import ptm_pkg::*;
#(
  parameter int unsigned CNT_W = ptm_pkg::PTM_CNT_W
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic tick,
  input wire logic [ptm_pkg::PTM_ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  output logic pin_out,
  output logic pin_oe,
  output logic match_a_flag,
  output logic match_p_flag
);
  import ptm_pkg::*;

  // Elaboration checks: the logic below is written for a 10-bit count
  // held in byte-wide registers and cannot serve other shapes.
  if (CNT_W != PTM_CNT_W) begin : g_bad_width
    $error("ptm_timer supports only a 10-bit counter");
  end
  if ($bits(PTM_OFS_CTRL0) != PTM_ADDR_W) begin : g_bad_addr
    $error("ptm_timer register offsets do not fit the address port");
  end
  if (PTM_BIT_MODE_HI != PTM_BIT_MODE_LO + 1) begin : g_bad_mode
    $error("ptm_timer mode field must be two adjacent bits");
  end
  if (PTM_BIT_ACT_HI != PTM_BIT_ACT_LO + 1) begin : g_bad_act
    $error("ptm_timer pin action field must be two adjacent bits");
  end
  if (PTM_BIT_MODE_HI >= $bits(wdata)) begin : g_bad_pos
    $error("ptm_timer control field lies outside the data byte");
  end
  if ((PTM_BIT_FLAG_A == PTM_BIT_ON) || (PTM_BIT_FLAG_P == PTM_BIT_ON)) begin : g_bad_flag
    $error("ptm_timer flag clear bits overlap the counter-on bit");
  end
  if (PTM_BIT_FLAG_A == PTM_BIT_FLAG_P) begin : g_bad_flags
    $error("ptm_timer flag clear bits must differ");
  end
  if (PTM_CNT_MAX != ~PTM_CNT_ZERO) begin : g_bad_max
    $error("ptm_timer maximum count must be all ones");
  end

  // Length of a full-range period, used when the period value is zero
  localparam logic [10:0] PTM_PER_FULL = 11'(PTM_CNT_MAX) + 11'(PTM_CNT_ONE);

  logic [9:0] cnt_q;
  logic [9:0] cmpa_q;
  logic [9:0] per_q;
  logic counter_on_q;
  logic on_prev_q;
  logic [1:0] mode_select_q;
  logic [1:0] pin_action_select_q;
  logic output_initial_level_q;
  logic output_invert_q;
  logic clear_source_select_q;
  logic capts_q;
  logic pin_q;
  logic pwm_q;

  wire logic on_rise = counter_on_q & ~on_prev_q;

  // Mode decode: which mode runs the waveform and which modes own the pin
  logic is_pwm;
  logic drive_pin;
  always_comb begin
    is_pwm = 1'b0;
    drive_pin = 1'b0;
    unique case (mode_select_q)
      PTM_MODE_CMP: begin
        drive_pin = 1'b1;
      end
      PTM_MODE_PWM: begin
        is_pwm = 1'b1;
        drive_pin = 1'b1;
      end
      // Capture and timer/counter modes count as compare mode, pin released
      PTM_MODE_CAP: begin
        drive_pin = 1'b0;
      end
      PTM_MODE_TMR: begin
        drive_pin = 1'b0;
      end
    endcase
  end
  wire logic run = counter_on_q & tick & ~on_rise;

  // Match when the counter reaches a nonzero compare value
  function automatic logic hit(input logic [9:0] c, input logic [9:0] v);
    hit = (v != PTM_CNT_ZERO) && (c == v);
  endfunction

  // Register write decode, shared by every register process
  function automatic logic wr_at(input logic w, input logic [2:0] a, input logic [2:0] ofs);
    wr_at = w && (a == ofs);
  endfunction

  // Byte views of a 10-bit value; spare high bits read zero
  function automatic logic [7:0] lo_byte(input logic [9:0] v);
    lo_byte = v[7:0];
  endfunction
  function automatic logic [7:0] hi_byte(input logic [9:0] v);
    hi_byte = {6'h00, v[9:8]};
  endfunction

  // Matches look at the value the counter is about to take, so the counter
  // never rests on a clearing value and a period value P gives P counts.
  wire logic [9:0] cnt_inc = 10'(cnt_q + PTM_CNT_ONE);
  wire logic a_eq = hit(cnt_inc, cmpa_q);
  wire logic p_eq = hit(cnt_inc, per_q);
  wire logic ovf = cnt_q == PTM_CNT_MAX;
  // Compare A of zero never matches, so no A flag then
  wire logic a_match = run & a_eq;
  wire logic p_allowed = is_pwm | ~clear_source_select_q;
  wire logic p_match = run & p_eq & p_allowed;

  // Counter clear decision per mode
  logic clr_now;
  always_comb begin
    clr_now = 1'b0;
    if (is_pwm) begin
      clr_now = (per_q == PTM_CNT_ZERO) ? ovf : p_eq;
    end else if (clear_source_select_q) begin
      clr_now = a_eq | ovf;
    end else begin
      clr_now = (per_q == PTM_CNT_ZERO) ? ovf : p_eq;
    end
  end

  // Counter
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= PTM_CNT_ZERO;
    end else if (on_rise) begin
      cnt_q <= PTM_CNT_ZERO;
    end else if (run) begin
      cnt_q <= clr_now ? PTM_CNT_ZERO : cnt_inc;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      on_prev_q <= 1'b0;
    end else begin
      on_prev_q <= counter_on_q;
    end
  end

  // Counter-on bit in control zero; own process so a control one
  // write can never disturb the run state
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      counter_on_q <= 1'b0;
    end else if (wr_at(wr, addr, PTM_OFS_CTRL0)) begin
      counter_on_q <= wdata[PTM_BIT_ON];
    end
  end

  // Control one fields
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      mode_select_q <= PTM_MODE_CMP;
      pin_action_select_q <= PTM_ACT_NONE;
      output_initial_level_q <= 1'b0;
      output_invert_q <= 1'b0;
      capts_q <= 1'b0;
      clear_source_select_q <= 1'b0;
    end else if (wr_at(wr, addr, PTM_OFS_CTRL1)) begin
      mode_select_q <= wdata[PTM_BIT_MODE_HI:PTM_BIT_MODE_LO];
      pin_action_select_q <= wdata[PTM_BIT_ACT_HI:PTM_BIT_ACT_LO];
      output_initial_level_q <= wdata[PTM_BIT_INIT];
      output_invert_q <= wdata[PTM_BIT_INV];
      capts_q <= wdata[PTM_BIT_CLRSRC+1];
      clear_source_select_q <= wdata[PTM_BIT_CLRSRC];
    end
  end

  // Compare value A; bytes land independently, no latching of a pair
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cmpa_q <= PTM_CNT_ZERO;
    end else begin
      if (wr_at(wr, addr, PTM_OFS_CMPA_LOW)) begin
        cmpa_q[7:0] <= wdata;
      end
      if (wr_at(wr, addr, PTM_OFS_CMPA_HIGH)) begin
        cmpa_q[9:8] <= wdata[1:0];
      end
    end
  end

  // Period value P
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      per_q <= PTM_CNT_ZERO;
    end else begin
      if (wr_at(wr, addr, PTM_OFS_PER_LOW)) begin
        per_q[7:0] <= wdata;
      end
      if (wr_at(wr, addr, PTM_OFS_PER_HIGH)) begin
        per_q[9:8] <= wdata[1:0];
      end
    end
  end

  // Sticky flags; write one to a flag bit of control zero clears it.
  // A match in the clearing cycle wins.
  wire logic clr_a = wr_at(wr, addr, PTM_OFS_CTRL0) & wdata[PTM_BIT_FLAG_A];
  wire logic clr_p = wr_at(wr, addr, PTM_OFS_CTRL0) & wdata[PTM_BIT_FLAG_P];
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      match_a_flag <= 1'b0;
      match_p_flag <= 1'b0;
    end else begin
      if (a_match) begin
        match_a_flag <= 1'b1;
      end else if (clr_a) begin
        match_a_flag <= 1'b0;
      end
      if (p_match) begin
        match_p_flag <= 1'b1;
      end else if (clr_p) begin
        match_p_flag <= 1'b0;
      end
    end
  end

  // Compare-mode pin level, before polarity
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pin_q <= 1'b0;
    end else if (on_rise) begin
      pin_q <= output_initial_level_q;
    end else if (a_match) begin
      // Only the A match moves the pin
      unique case (pin_action_select_q)
        PTM_ACT_LOW: pin_q <= 1'b0;
        PTM_ACT_HIGH: pin_q <= 1'b1;
        PTM_ACT_TOGGLE: pin_q <= ~pin_q;
        PTM_ACT_NONE: pin_q <= pin_q;
      endcase
    end
  end

  // PWM waveform: active while count below duty, full on when duty >= period
  logic [10:0] period_len;
  always_comb begin
    period_len = (per_q == PTM_CNT_ZERO) ? PTM_PER_FULL : {1'b0, per_q};
  end
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pwm_q <= 1'b0;
    end else if (on_rise) begin
      pwm_q <= 1'b0;
    end else begin
      pwm_q <= ({1'b0, cmpa_q} >= period_len) | (cnt_q < cmpa_q);
    end
  end

  // Output pin, registered; invert applies in every mode
  logic pin_d;
  always_comb begin
    pin_d = pin_q;
    if (is_pwm) begin
      unique case (pin_action_select_q)
        PTM_PWM_INACT: pin_d = ~output_initial_level_q;
        PTM_PWM_ACT: pin_d = output_initial_level_q;
        PTM_PWM_WAVE: pin_d = pwm_q ? output_initial_level_q : ~output_initial_level_q;
        default: pin_d = ~output_initial_level_q;
      endcase
    end
  end
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pin_out <= 1'b0;
    end else begin
      pin_out <= pin_d ^ output_invert_q;
    end
  end

  // Timer/counter and capture modes release the pin
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pin_oe <= 1'b0;
    end else begin
      pin_oe <= drive_pin;
    end
  end

  // Read port, one cycle latency
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rdata <= PTM_RST_BYTE;
    end else if (rd) begin
      unique case (addr)
        PTM_OFS_CTRL0: rdata <= {4'h0, counter_on_q, 1'b0, match_a_flag, match_p_flag};
        PTM_OFS_CTRL1: rdata <= {mode_select_q, pin_action_select_q, output_initial_level_q,
                                 output_invert_q, capts_q, clear_source_select_q};
        PTM_OFS_CNT_LOW: rdata <= lo_byte(cnt_q);
        PTM_OFS_CNT_HIGH: rdata <= hi_byte(cnt_q);
        PTM_OFS_CMPA_LOW: rdata <= lo_byte(cmpa_q);
        PTM_OFS_CMPA_HIGH: rdata <= hi_byte(cmpa_q);
        PTM_OFS_PER_LOW: rdata <= lo_byte(per_q);
        PTM_OFS_PER_HIGH: rdata <= hi_byte(per_q);
      endcase
    end
  end
endmodule // ptm_timer

`default_nettype wire

// ---- test/ptm_timer_asserts.sv ----
// Port checker for ptm_timer, bound to the top module.
// Mirrors control one from register writes; sees only top ports.
`timescale 1ns/10ps
`default_nettype none
module ptm_asserts (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic tick,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic pin_out,
  input wire logic pin_oe,
  input wire logic match_a_flag,
  input wire logic match_p_flag
);
  logic [7:0] c1_q;
  logic [1:0] age_q;
  logic [3:0] ev_q;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) c1_q <= 8'h00;
    else if (wr && addr == 3'h1) c1_q <= wdata;
  end
  // Settling age after a control write; outputs lag by registers
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) age_q <= 2'h0;
    else if (wr && addr == 3'h1) age_q <= 2'h0;
    else if (age_q != 2'h3) age_q <= age_q + 2'h1;
  end
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) ev_q <= 4'h0;
    else ev_q <= {ev_q[2:0], tick | wr};
  end
  property p_hi_zero; rd && addr[0] && addr != 3'h1 |=> rdata[7:2] == 6'h00; endproperty
  a_hi_zero: assert property (p_hi_zero) else $error("high byte spare bits set");
  property p_rd_hold; !$past(rd) |-> $stable(rdata); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_a_keep; match_a_flag && !(wr && addr == 3'h0 && wdata[1]) |=> match_a_flag; endproperty
  a_a_keep: assert property (p_a_keep) else $error("A flag dropped");
  property p_p_keep; match_p_flag && !(wr && addr == 3'h0 && wdata[0]) |=> match_p_flag; endproperty
  a_p_keep: assert property (p_p_keep) else $error("P flag dropped");
  property p_a_clr; wr && addr == 3'h0 && wdata[1] && !tick && !$past(tick) |=> !match_a_flag;
  endproperty
  a_a_clr: assert property (p_a_clr) else $error("A flag not cleared");
  property p_a_rise; $rose(match_a_flag) |-> $past(tick) || $past(tick, 2); endproperty
  a_a_rise: assert property (p_a_rise) else $error("A flag without a count");
  property p_p_none; $rose(match_p_flag) |-> $past(c1_q[7:6] == 2'b10 || !c1_q[0]); endproperty
  a_p_none: assert property (p_p_none) else $error("P flag with A clearing");
  property p_oe; age_q == 2'h3 |-> pin_oe == !c1_q[6]; endproperty
  a_oe: assert property (p_oe) else $error("output enable wrong for mode");
  property p_pin_evt; c1_q[7:6] == 2'b00 && age_q == 2'h3 && $changed(pin_out) |-> |ev_q;
  endproperty
  a_pin_evt: assert property (p_pin_evt) else $error("pin moved with no event");
endmodule // ptm_asserts
bind ptm_timer ptm_asserts u_chk (.mclk(mclk), .resetn(resetn), .tick(tick), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .pin_out(pin_out), .pin_oe(pin_oe),
  .match_a_flag(match_a_flag), .match_p_flag(match_p_flag));
`default_nettype wire

// ---- test/ptm_timer_tb.sv ----
// Self-checking bench for ptm_timer: registers, compare, timer and PWM.
// Drives register port and tick directly; no far-side model.
`timescale 1ns/10ps
`default_nettype none
module ptm_timer_tb;
  logic mclk = 1'b0, resetn = 1'b0, tick = 1'b0, wr = 1'b0, rd = 1'b0, b;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00, rdata, r, hc;
  logic pin_out, pin_oe, fa, fp;
  logic [9:0] v [2];
  int n_mismatch = 0;
  int check_count = 0;
  ptm_timer dut (.mclk(mclk), .resetn(resetn), .tick(tick), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .pin_out(pin_out), .pin_oe(pin_oe),
    .match_a_flag(fa), .match_p_flag(fp));
  always #4 mclk = ~mclk;
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR t=%0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wt(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task automatic rt(input logic [2:0] a);
    @(posedge mclk);
    rd <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    #1 r = rdata;
  endtask
  // Spaced ticks so flag and pin registers settle before sampling
  task automatic tk(input int n);
    repeat (n) begin
      @(posedge mclk);
      tick <= 1'b1;
      @(posedge mclk);
      tick <= 1'b0;
      repeat (4) @(posedge mclk);
    end
  endtask
  // Off then on: counter restarts, flags cleared by write-one
  task automatic on(input logic [7:0] c1);
    wt(3'h1, c1);
    wt(3'h0, 8'h00);
    wt(3'h0, 8'h0b);
    repeat (4) @(posedge mclk);
  endtask
  task automatic pw(input logic [7:0] a, input logic [7:0] c1, input logic [7:0] e);
    wt(3'h4, a);
    on(c1);
    tk(8);
    hc = 8'h00;
    repeat (8) begin
      tk(1);
      hc = hc + {7'h0, pin_out};
    end
    chk(hc, e);
  endtask
  function automatic logic pe(input int k, input logic i);
    return (k == 0) ? i : (k == 3) ? ~i : (k == 2);
  endfunction
  initial begin
    #200000;
    n_mismatch++;
    end_of_test();
  end
  initial begin
    void'($urandom(41));
    repeat (20) @(posedge mclk);
    resetn <= 1'b1;
    for (int i = 1; i < 8; i++) begin
      rt(i[2:0]);
      chk(r, 8'h00);
    end
    v[0] = 10'($urandom);
    v[1] = 10'($urandom);
    for (int i = 0; i < 4; i++) wt(3'(4 + i), i[0] ? {6'h3f, v[i/2][9:8]} : v[i/2][7:0]);
    wt(3'h3, 8'hff);
    for (int i = 0; i < 4; i++) begin
      rt(3'(4 + i));
      chk(r, i[0] ? {6'h00, v[i/2][9:8]} : v[i/2][7:0]);
    end
    rt(3'h3);
    chk(r, 8'h00);
    wt(3'h4, 8'h04);
    wt(3'h5, 8'h00);
    wt(3'h6, 8'h09);
    wt(3'h7, 8'h00);
    for (int k = 0; k < 4; k++) begin
      b = 1'($urandom);
      on({2'b00, 2'(k), b, 3'b000});
      chk({7'h0, pin_out}, {7'h0, b});
      tk(3);
      chk({6'h0, fa, pin_out}, {7'h0, b});
      tk(7);
      chk({5'h0, fp, fa, pin_out}, {6'h03, pe(k, b)});
    end
    on(8'h00);
    tk(3);
    wt(3'h0, 8'h00);
    tk(2);
    rt(3'h2);
    chk(r, 8'h03);
    on(8'h00);
    rt(3'h2);
    chk(r, 8'h00);
    wt(3'h6, 8'h02);
    on(8'h01);
    tk(12);
    chk({6'h0, fp, fa}, 8'h01);
    wt(3'h6, 8'h09);
    on(8'hc0);
    tk(5);
    chk({6'h0, pin_oe, fa}, 8'h01);
    wt(3'h4, 8'h00);
    on(8'h00);
    tk(12);
    chk({7'h0, fa}, 8'h00);
    wt(3'h6, 8'h08);
    pw(8'h03, 8'ha9, 8'h03);
    chk({6'h0, fp, fa}, 8'h03);
    pw(8'h03, 8'hac, 8'h05);
    pw(8'h03, 8'ha0, 8'h05);
    pw(8'h09, 8'ha8, 8'h08);
    pw(8'h03, 8'h88, 8'h00);
    pw(8'h03, 8'h98, 8'h08);
    end_of_test();
  end
endmodule // ptm_timer_tb
`default_nettype wire
